// File: stop_gate_pkg.sv
// Constants and types shared by the stop-mode peripheral gating block.
package stop_gate_pkg;

   // ===================================================================
   // Register bus
   // ===================================================================
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CLKCFG_OFS = 8'h01;
   localparam logic [7:0] STATUS_OFS = 8'h02;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CLKCFG_RST = 8'h00;

   // ===================================================================
   // Control register fields
   // ===================================================================
   localparam int STOP_INSTR_ENABLE_BIT = 0;
   localparam int DEBUG_MODE_ENABLE_BIT = 1;
   localparam int LOW_VOLT_DET_EN_BIT = 2;
   localparam int LOW_VOLT_DET_STOP_EN_BIT = 3;
   localparam int POWER_DOWN_CTRL_BIT = 4;
   localparam int PARTIAL_POWER_DOWN_SEL_BIT = 5;

   // ===================================================================
   // Clock configuration register fields
   // ===================================================================
   localparam int INTERNAL_REF_CLOCK_EN_BIT = 0;
   localparam int INTERNAL_REF_STOP_EN_BIT = 1;
   localparam int EXTERNAL_REF_CLOCK_EN_BIT = 2;
   localparam int EXTERNAL_REF_STOP_EN_BIT = 3;
   localparam int OSC_HIGH_RANGE_BIT = 4;
   localparam int ADC_ASYNC_CLK_EN_BIT = 5;

   // ===================================================================
   // Status register fields
   // ===================================================================
   localparam int STATUS_MODE_LSB = 0;
   localparam int STATUS_STATE_LSB = 2;
   localparam int STATUS_CLK_STABLE_BIT = 4;

   // ===================================================================
   // Types
   // ===================================================================
   typedef enum logic [1:0] {MODE_NONE, MODE_DEEP, MODE_RAM, MODE_STANDBY} stop_mode_t;
   typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAKE} pwr_state_t;

endpackage

// File: stop_gate.sv
// Stop-mode sequencer that gates peripheral clocks and sets power and pin states.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps

// What this block does
// - Stop with stop enabled enters one mode chosen by debug, detector and power-down bits.
// - In every stop mode the peripheral module clocks are switched off.
// - With debug enabled the debug logic keeps its clock while all other peripheral clocks halt.
// - Deep stop floats all pins, the other two stop modes hold pin states.
// - RAM is off in deep stop and kept in standby in the two other stop modes.
// - In standby stop the converter runs only with its async clock and the voltage detector kept on in stop.
// - In standby stop the clock generator runs only with both internal reference enables set.
// - In standby stop the crystal oscillator runs only with both external reference enables set.
// - In high frequency range the oscillator also needs the voltage detector kept on in stop.
module stop_gate (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [stop_gate_pkg::ADDR_W-1:0] addr_i,
   input wire logic [stop_gate_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [stop_gate_pkg::DATA_W-1:0] rdata_o,
   input wire logic stop_instr_i,
   input wire logic wake_i,
   input wire logic clk_stable_i,
   output logic illegal_stop_o,
   output logic [1:0] stop_mode_o,
   output logic periph_clk_en_o,
   output logic debug_clk_en_o,
   output logic pins_hiz_o,
   output logic pins_hold_o,
   output logic ram_off_o,
   output logic ram_standby_o,
   output logic regulator_off_o,
   output logic regulator_standby_o,
   output logic adc_run_o,
   output logic clk_gen_run_o,
   output logic crystal_osc_run_o
);
   import stop_gate_pkg::*;

   // ===================================================================
   // State
   // ===================================================================
   typedef struct packed {
      pwr_state_t st;
      stop_mode_t mode;
      logic [DATA_W-1:0] ctrl;
      logic [DATA_W-1:0] clkcfg;
      logic [DATA_W-1:0] rdata;
      logic wake_s1;
      logic wake_s2;
      logic stab_s1;
      logic stab_s2;
      logic illegal;
      logic periph_en;
      logic debug_en;
      logic hiz;
      logic hold;
      logic ram_off;
      logic ram_stby;
      logic reg_off;
      logic reg_stby;
      logic adc_run;
      logic icg_run;
      logic osc_run;
   } gate_state_t;

   localparam gate_state_t STATE_RST = '{st: ST_RUN, mode: MODE_NONE, ctrl: CTRL_RST,
      clkcfg: CLKCFG_RST, rdata: '0, wake_s1: 1'b0, wake_s2: 1'b0, stab_s1: 1'b0,
      stab_s2: 1'b0, illegal: 1'b0, periph_en: 1'b1, debug_en: 1'b1, hiz: 1'b0,
      hold: 1'b0, ram_off: 1'b0, ram_stby: 1'b0, reg_off: 1'b0, reg_stby: 1'b0,
      adc_run: 1'b1, icg_run: 1'b1, osc_run: 1'b1};

   gate_state_t s_q;
   gate_state_t s_d;

   // The voltage detector counts as kept on in stop only when both of its enables are set.
   function automatic logic volt_det_in_stop(input logic [DATA_W-1:0] c);
      volt_det_in_stop = c[LOW_VOLT_DET_EN_BIT] & c[LOW_VOLT_DET_STOP_EN_BIT];
   endfunction

   function automatic stop_mode_t select_mode(input logic [DATA_W-1:0] c);
      if (c[DEBUG_MODE_ENABLE_BIT] || volt_det_in_stop(c) || !c[POWER_DOWN_CTRL_BIT]) begin
         select_mode = MODE_STANDBY;
      end else if (c[PARTIAL_POWER_DOWN_SEL_BIT]) begin
         select_mode = MODE_RAM;
      end else begin
         select_mode = MODE_DEEP;
      end
   endfunction

   // ===================================================================
   // Next state
   // ===================================================================
   always_comb begin
      logic stopped;
      logic stby;
      stopped = 1'b0;
      stby = 1'b0;
      s_d = s_q;
      s_d.wake_s1 = wake_i;
      s_d.wake_s2 = s_q.wake_s1;
      s_d.stab_s1 = clk_stable_i;
      s_d.stab_s2 = s_q.stab_s1;
      s_d.illegal = 1'b0;
      s_d.rdata = '0;
      if (wr_i) begin
         case (addr_i)
            CTRL_OFS: s_d.ctrl = wdata_i;
            CLKCFG_OFS: s_d.clkcfg = wdata_i;
            default: s_d.ctrl = s_d.ctrl;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            CTRL_OFS: s_d.rdata = s_q.ctrl;
            CLKCFG_OFS: s_d.rdata = s_q.clkcfg;
            STATUS_OFS: begin
               s_d.rdata[STATUS_MODE_LSB +: 2] = s_q.mode;
               s_d.rdata[STATUS_STATE_LSB +: 2] = s_q.st;
               s_d.rdata[STATUS_CLK_STABLE_BIT] = s_q.stab_s2;
            end
            default: s_d.rdata = '0;
         endcase
      end
      case (s_q.st)
         ST_RUN: begin
            if (stop_instr_i) begin
               if (s_q.ctrl[STOP_INSTR_ENABLE_BIT]) begin
                  s_d.st = ST_STOP;
                  s_d.mode = select_mode(s_q.ctrl);
               end else begin
                  s_d.illegal = 1'b1;
               end
            end
         end
         ST_STOP: begin
            if (s_q.wake_s2) begin
               s_d.st = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (s_q.stab_s2) begin
               s_d.st = ST_RUN;
               s_d.mode = MODE_NONE;
            end
         end
         default: begin
            s_d.st = ST_RUN;
            s_d.mode = MODE_NONE;
         end
      endcase
      // Enables leave flip-flops only, so a downstream gate cell never sees a runt pulse.
      stopped = (s_d.st != ST_RUN);
      stby = stopped && (s_d.mode == MODE_STANDBY);
      s_d.periph_en = !stopped;
      s_d.debug_en = !stopped || (stby && s_d.ctrl[DEBUG_MODE_ENABLE_BIT]);
      s_d.hiz = stopped && (s_d.mode == MODE_DEEP);
      s_d.hold = stopped && (s_d.mode != MODE_DEEP);
      s_d.ram_off = stopped && (s_d.mode == MODE_DEEP);
      s_d.ram_stby = stopped && (s_d.mode != MODE_DEEP);
      s_d.reg_off = stopped && (s_d.mode == MODE_DEEP);
      s_d.reg_stby = (stopped && (s_d.mode == MODE_RAM)) ||
         (stby && !s_d.ctrl[DEBUG_MODE_ENABLE_BIT] && !volt_det_in_stop(s_d.ctrl));
      s_d.adc_run = !stopped ||
         (stby && s_d.clkcfg[ADC_ASYNC_CLK_EN_BIT] && volt_det_in_stop(s_d.ctrl));
      s_d.icg_run = !stopped || (stby && s_d.clkcfg[INTERNAL_REF_CLOCK_EN_BIT] &&
         s_d.clkcfg[INTERNAL_REF_STOP_EN_BIT]);
      s_d.osc_run = !stopped || (stby && s_d.clkcfg[EXTERNAL_REF_CLOCK_EN_BIT] &&
         s_d.clkcfg[EXTERNAL_REF_STOP_EN_BIT] &&
         (!s_d.clkcfg[OSC_HIGH_RANGE_BIT] || volt_det_in_stop(s_d.ctrl)));
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;
   assign illegal_stop_o = s_q.illegal;
   assign stop_mode_o = s_q.mode;
   assign periph_clk_en_o = s_q.periph_en;
   assign debug_clk_en_o = s_q.debug_en;
   assign pins_hiz_o = s_q.hiz;
   assign pins_hold_o = s_q.hold;
   assign ram_off_o = s_q.ram_off;
   assign ram_standby_o = s_q.ram_stby;
   assign regulator_off_o = s_q.reg_off;
   assign regulator_standby_o = s_q.reg_stby;
   assign adc_run_o = s_q.adc_run;
   assign clk_gen_run_o = s_q.icg_run;
   assign crystal_osc_run_o = s_q.osc_run;

   // ===================================================================
   // Assertions
   // ===================================================================
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   logic in_stop;
   logic in_stby;
   logic go_stop;
   assign in_stop = (s_q.st != ST_RUN);
   assign in_stby = in_stop && (s_q.mode == MODE_STANDBY);
   assign go_stop = (s_q.st == ST_RUN) && stop_instr_i && s_q.ctrl[STOP_INSTR_ENABLE_BIT];

   property p_stop_entry;
      go_stop |=> (s_q.st == ST_STOP) && (s_q.mode == select_mode($past(s_q.ctrl)));
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("Stop entry mode wrong.");

   property p_stop_refused;
      (s_q.st == ST_RUN) && stop_instr_i && !s_q.ctrl[STOP_INSTR_ENABLE_BIT]
         |=> illegal_stop_o && (s_q.st == ST_RUN) ##1 !illegal_stop_o;
   endproperty
   a_stop_refused: assert property (p_stop_refused) else $error("Disabled stop taken.");

   property p_clk_off;
      in_stop |-> !periph_clk_en_o;
   endproperty
   a_clk_off: assert property (p_clk_off) else $error("Peripheral clock on in stop.");

   property p_debug_clk;
      in_stop && s_q.ctrl[DEBUG_MODE_ENABLE_BIT] |-> debug_clk_en_o && !periph_clk_en_o;
   endproperty
   a_debug_clk: assert property (p_debug_clk) else $error("Debug clock gated.");

   property p_pins;
      in_stop |-> (pins_hiz_o == (s_q.mode == MODE_DEEP)) && (pins_hold_o != pins_hiz_o);
   endproperty
   a_pins: assert property (p_pins) else $error("Pin state wrong in stop.");

   property p_ram;
      in_stop |-> (ram_off_o == (s_q.mode == MODE_DEEP)) && (ram_standby_o == !ram_off_o);
   endproperty
   a_ram: assert property (p_ram) else $error("RAM power wrong in stop.");

   property p_adc;
      in_stby |-> adc_run_o == (s_q.clkcfg[ADC_ASYNC_CLK_EN_BIT] && volt_det_in_stop(s_q.ctrl));
   endproperty
   a_adc: assert property (p_adc) else $error("Converter state wrong.");

   property p_icg;
      in_stby |-> clk_gen_run_o == (s_q.clkcfg[INTERNAL_REF_CLOCK_EN_BIT] &&
         s_q.clkcfg[INTERNAL_REF_STOP_EN_BIT]);
   endproperty
   a_icg: assert property (p_icg) else $error("Clock generator state wrong.");

   property p_osc;
      in_stop && crystal_osc_run_o |-> in_stby && s_q.clkcfg[EXTERNAL_REF_CLOCK_EN_BIT] &&
         s_q.clkcfg[EXTERNAL_REF_STOP_EN_BIT];
   endproperty
   a_osc: assert property (p_osc) else $error("Oscillator kept without enables.");

   property p_osc_range;
      in_stop && s_q.clkcfg[OSC_HIGH_RANGE_BIT] && !volt_det_in_stop(s_q.ctrl)
         |-> !crystal_osc_run_o;
   endproperty
   a_osc_range: assert property (p_osc_range) else $error("High range without detector.");

   property p_wake;
      $rose(periph_clk_en_o) |-> $past(s_q.st == ST_WAKE) && $past(s_q.stab_s2);
   endproperty
   a_wake: assert property (p_wake) else $error("Clock restored before stable.");

   c_deep: cover property (go_stop ##1 (s_q.mode == MODE_DEEP));
   c_ram: cover property (go_stop ##1 (s_q.mode == MODE_RAM));
   c_debug: cover property (in_stby && debug_clk_en_o);
   c_wake: cover property ((s_q.st == ST_WAKE) ##1 (s_q.st == ST_RUN));
endmodule

// File: tb.sv
// Self-checking testbench for the stop-mode peripheral gating block.
`timescale 1ns/1ps
module tb;
   import stop_gate_pkg::*;
   // ==================================================================
   // Clock, reset and design
   // ==================================================================
   typedef struct {logic [7:0] ctrl; logic [7:0] cfg; logic [1:0] mode;} row_t;
   logic sys_clk_i, rst_b_i, wr_i, rd_i, stop_instr_i, wake_i, clk_stable_i;
   logic [7:0] addr_i, wdata_i, rdata_o, rd_val;
   logic illegal_stop_o, periph_clk_en_o, debug_clk_en_o, pins_hiz_o, pins_hold_o;
   logic ram_off_o, ram_standby_o, regulator_off_o, regulator_standby_o;
   logic adc_run_o, clk_gen_run_o, crystal_osc_run_o, s1, s2;
   logic [1:0] stop_mode_o;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;
   row_t rows[8] = '{'{8'h03, 8'h00, 2'h3}, '{8'h0D, 8'h3F, 2'h3}, '{8'h01, 8'h1F, 2'h3},
      '{8'h31, 8'h3F, 2'h2}, '{8'h11, 8'h3F, 2'h1}, '{8'h05, 8'h2C, 2'h3},
      '{8'h1F, 8'h01, 2'h3}, '{8'h39, 8'h3F, 2'h2}};

   stop_gate i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .stop_instr_i(stop_instr_i), .wake_i(wake_i), .clk_stable_i(clk_stable_i),
      .illegal_stop_o(illegal_stop_o), .stop_mode_o(stop_mode_o),
      .periph_clk_en_o(periph_clk_en_o), .debug_clk_en_o(debug_clk_en_o),
      .pins_hiz_o(pins_hiz_o), .pins_hold_o(pins_hold_o), .ram_off_o(ram_off_o),
      .ram_standby_o(ram_standby_o), .regulator_off_o(regulator_off_o),
      .regulator_standby_o(regulator_standby_o), .adc_run_o(adc_run_o),
      .clk_gen_run_o(clk_gen_run_o), .crystal_osc_run_o(crystal_osc_run_o));

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // ==================================================================
   // Tasks
   // ==================================================================
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 rd_val = rdata_o;
   endtask

   task automatic pulse_stop();
      @(posedge sys_clk_i);
      stop_instr_i <= 1'b1;
      @(posedge sys_clk_i);
      stop_instr_i <= 1'b0;
      #1 s1 = illegal_stop_o;
   endtask

   task automatic chk_run();
      chk("periph_clk_en", 8'(periph_clk_en_o), 8'h01);
      chk("stop_mode", 8'(stop_mode_o), 8'h00);
      chk("run_outputs", {5'h00, adc_run_o, clk_gen_run_o, crystal_osc_run_o}, 8'h07);
      chk("pin_ram_reg", {3'h0, pins_hiz_o, pins_hold_o, ram_off_o, ram_standby_o,
         regulator_off_o}, 8'h00);
   endtask

   task automatic chk_stop(input row_t r);
      logic lvs, st, deep;
      lvs = r.ctrl[2] & r.ctrl[3];
      st = (r.mode == 2'h3);
      deep = (r.mode == 2'h1);
      chk("stop_mode", 8'(stop_mode_o), 8'(r.mode));
      chk("periph_clk_en", 8'(periph_clk_en_o), 8'h00);
      chk("debug_clk_en", 8'(debug_clk_en_o), 8'(st & r.ctrl[1]));
      chk("pins", {6'h00, pins_hiz_o, pins_hold_o}, {6'h00, deep, !deep});
      chk("ram", {6'h00, ram_off_o, ram_standby_o}, {6'h00, deep, !deep});
      chk("reg_off", 8'(regulator_off_o), 8'(deep));
      chk("reg_stby", 8'(regulator_standby_o),
         8'((r.mode == 2'h2) | (st & !r.ctrl[1] & !lvs)));
      chk("adc_run", 8'(adc_run_o), 8'(st & r.cfg[5] & lvs));
      chk("clk_gen_run", 8'(clk_gen_run_o), 8'(st & r.cfg[0] & r.cfg[1]));
      chk("osc_run", 8'(crystal_osc_run_o),
         8'(st & r.cfg[2] & r.cfg[3] & (!r.cfg[4] | lvs)));
   endtask

   // ==================================================================
   // Stimulus
   // ==================================================================
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles > 5000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      rst_b_i = 1'b0;
      {wr_i, rd_i, stop_instr_i, wake_i, clk_stable_i} = 5'h00;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      #1 chk_run();
      // Table of stop entries, each followed by a full wake.
      foreach (rows[i]) begin
         reg_wr(CTRL_OFS, rows[i].ctrl);
         reg_wr(CLKCFG_OFS, rows[i].cfg);
         pulse_stop();
         @(posedge sys_clk_i);
         #1 chk_stop(rows[i]);
         reg_rd(STATUS_OFS);
         chk("status", rd_val, {4'h0, 2'h1, rows[i].mode});
         @(posedge sys_clk_i);
         wake_i <= 1'b1;
         repeat (6) @(posedge sys_clk_i);
         #1 chk("periph_early", 8'(periph_clk_en_o), 8'h00);
         reg_rd(STATUS_OFS);
         chk("status_wake", rd_val, {4'h0, 2'h2, rows[i].mode});
         @(posedge sys_clk_i);
         clk_stable_i <= 1'b1;
         n = 0;
         while (n < 12 && periph_clk_en_o !== 1'b1) begin
            @(posedge sys_clk_i);
            #1 n++;
         end
         chk("wake_delay", 8'(n >= 3 && n < 10), 8'h01);
         chk_run();
         reg_rd(STATUS_OFS);
         chk("status_run", rd_val, 8'h10);
         @(posedge sys_clk_i);
         wake_i <= 1'b0;
         clk_stable_i <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
      end
      // Register access: read-back of both registers and an unmapped place.
      reg_wr(CTRL_OFS, 8'h2A);
      reg_wr(CLKCFG_OFS, 8'h15);
      reg_wr(8'h07, 8'h3F);
      reg_rd(CTRL_OFS);
      chk("ctrl", rd_val, 8'h2A);
      reg_rd(CLKCFG_OFS);
      chk("clkcfg", rd_val, 8'h15);
      reg_rd(8'h07);
      chk("unmapped", rd_val, 8'h00);
      // Reset in the middle of a deep stop brings back run outputs and the control register reset value.
      reg_wr(CTRL_OFS, 8'h11);
      pulse_stop();
      chk("hiz_before_rst", 8'(pins_hiz_o), 8'h01);
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      #1 chk_run();
      reg_rd(CTRL_OFS);
      chk("ctrl_rst", rd_val, CTRL_RST);
      @(posedge sys_clk_i);
      #1 chk("rdata_idle", rdata_o, 8'h00);
      // Stop with the stop enable clear is refused with a one-cycle flag.
      reg_wr(CTRL_OFS, 8'h00);
      pulse_stop();
      @(posedge sys_clk_i);
      #1 s2 = illegal_stop_o;
      chk("illegal", {6'h00, s1, s2}, 8'h02);
      chk_run();
      finish_test();
   end
endmodule
